//--- pkg/ssvs_pkg.sv
// constants, types and decode functions for the start-up sequencer
// assumes a single 100 MHz system clock; voltages are carried in millivolts
package ssvs_pkg;

  // ==========================================================
  // clock and timing
  localparam int CLK_FREQ_HZ = 100_000_000;
  localparam int MS_PER_S = 1000;
  localparam int MS_CYCLES = CLK_FREQ_HZ / MS_PER_S;
  localparam int MEMCHK_TIME_MS = 5;
  localparam int PRERAMP_MIN_MS = 2;
  localparam int MS_CNT_W = 8;

  // ==========================================================
  // voltages in millivolts
  localparam int MV_W = 13;
  localparam int RES_CODE_W = 5;
  localparam logic [MV_W-1:0] VOUT_MIN_MV = 13'h0258;
  localparam logic [MV_W-1:0] OUTPUT_VOLTAGE_CEILING_MV = 13'h1388;
  localparam logic [MV_W-1:0] VOUT_STRAP_LOW_MV = 13'h04B0;
  localparam logic [MV_W-1:0] VOUT_STRAP_OPEN_MV = 13'h05DC;
  localparam logic [MV_W-1:0] VOUT_STRAP_HIGH_MV = 13'h0CE4;
  localparam logic [MV_W-1:0] VOUT_STEP_MV = 13'h0064;
  localparam logic [RES_CODE_W-1:0] RES_STEP_BASE = 5'h0B;
  localparam logic [RES_CODE_W-1:0] RES_CODE_MAX = 5'h1E;
  localparam logic [MV_W-1:0] CEIL_DIV = 13'h000A;

  // ==========================================================
  // types
  typedef enum logic [1:0] {
    PIN_LOW,
    PIN_OPEN,
    PIN_HIGH,
    PIN_RES
  } ssvs_pin_class_t;

  typedef enum logic [2:0] {
    ST_OFF,
    ST_MEMCHK,
    ST_PINLD,
    ST_READY,
    ST_DELAY,
    ST_RAMP,
    ST_ON
  } ssvs_state_t;

  // ==========================================================
  // resistor code to target voltage
  function automatic logic [MV_W-1:0] ssvs_res_mv(
    input logic [RES_CODE_W-1:0] code
  );
    logic [MV_W-1:0] mv;
    mv = OUTPUT_VOLTAGE_CEILING_MV;
    case (code)
      5'h00: mv = 13'h0258;
      5'h01: mv = 13'h02BC;
      5'h02: mv = 13'h02EE;
      5'h03: mv = 13'h0320;
      5'h04: mv = 13'h0384;
      5'h05: mv = 13'h03E8;
      5'h06: mv = 13'h044C;
      5'h07: mv = 13'h04B0;
      5'h08: mv = 13'h04E2;
      5'h09: mv = 13'h0514;
      5'h0A: mv = 13'h0578;
      default: begin
        // codes 11..29 climb in even 100 mV steps from 1.5 V
        if (code < RES_CODE_MAX) begin
          mv = MV_W'(VOUT_STRAP_OPEN_MV
               + MV_W'(code - RES_STEP_BASE) * VOUT_STEP_MV);
        end
      end
    endcase
    return mv;
  endfunction : ssvs_res_mv

  // ceiling sits ten percent above the pin-selected voltage
  function automatic logic [MV_W-1:0] ssvs_ceiling(
    input logic [MV_W-1:0] mv
  );
    return MV_W'(mv + mv / CEIL_DIV);
  endfunction : ssvs_ceiling

endpackage : ssvs_pkg

//--- pkg/ssvs_pin_if.sv
// decoded output-voltage select pin, passed from decoder to sequencer
// assumes the decoder drives it combinationally
`timescale 1ns/1ns
interface ssvs_pin_if;
  ssvs_pkg::ssvs_pin_class_t pin_class;
  logic [ssvs_pkg::RES_CODE_W-1:0] res_code;
  modport dec (output pin_class, output res_code);
  modport seq (input pin_class, input res_code);
endinterface : ssvs_pin_if

//--- logic/ssvs_pin_decode.sv
// classifies the multi-mode output-voltage select pin
// assumes the analog front end gives level comparators and a resistor code
`timescale 1ns/1ns
module ssvs_pin_decode (
  // analog front end
  input wire logic pin_lvl_low,
  input wire logic pin_lvl_high,
  input wire logic pin_res_sense,
  input wire logic [ssvs_pkg::RES_CODE_W-1:0] pin_res_code,
  // decoded result
  ssvs_pin_if.dec pin
);

  // ==========================================================
  // classification
  always_comb begin
    // resistor sensing wins: a resistor also looks like a weak low
    if (pin_res_sense) begin // [RQ15]
      pin.pin_class = ssvs_pkg::PIN_RES;
    end else if (pin_lvl_high) begin
      pin.pin_class = ssvs_pkg::PIN_HIGH;
    end else if (pin_lvl_low) begin
      pin.pin_class = ssvs_pkg::PIN_LOW;
    end else begin
      pin.pin_class = ssvs_pkg::PIN_OPEN;
    end
    // out-of-range codes clamp to the top entry
    if (pin_res_code > ssvs_pkg::RES_CODE_MAX) begin
      pin.res_code = ssvs_pkg::RES_CODE_MAX;
    end else begin
      pin.res_code = pin_res_code;
    end
  end

endmodule : ssvs_pin_decode

//--- logic/ssvs_top.sv
// start-up sequencer and output-voltage selection
// assumes all inputs synchronous to sys_clk; restore and write are pulses
// What this block does
// [RQ1] start sequencing once both power-stage and bias supplies are present
// [RQ2] spend the memory-check interval ignoring enable and bus traffic
// [RQ3] rerun the memory check on every restore command
// [RQ4] load stored user values from nonvolatile memory during the check
// [RQ5] after the check, sample the select pin and load its setting
// [RQ6] accept bus commands and enable only once loading is done
// [RQ7] strap low, open, high select 1.2 V, 1.5 V, 3.3 V
// [RQ8] resistor codes map 31 entries from 0.6 V to 5.0 V
// [RQ9] host may write a 0.6 V to 5.0 V target overriding pins
// [RQ10] configured delay under 2 ms still waits 2 ms before ramp
// [RQ11] configured delay over 2 ms waits the full configured delay
// [RQ12] after the delay, ramp over the configured soft-start ramp time
// [RQ13] enable tied active still waits out memory and pin loading
// [RQ14] host keeps any external sync clock stable before enabling
// [RQ15] decode the select pin into low, open, high or resistor
// [RQ16] output ceiling is ten percent above the pin-selected voltage
// [RQ17] pre-ramp delay counts from the enable assertion; the code counts from ST_DELAY entry, so an early enable counts from ready
// [RQ18] an early enable level is acted on once ready
// [RQ19] expose sequencer state for visibility
`timescale 1ns/1ns
module ssvs_top #(
  parameter int MS_DIV = ssvs_pkg::MS_CYCLES
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // supplies
  input wire logic power_stage_supply,
  input wire logic bias_supply,
  // nonvolatile memory
  input wire logic nvm_valid,
  input wire logic [ssvs_pkg::MV_W-1:0] nvm_vout_mv,
  // output-voltage select pin front end
  input wire logic vsel_lvl_low,
  input wire logic vsel_lvl_high,
  input wire logic vsel_res_sense,
  input wire logic [ssvs_pkg::RES_CODE_W-1:0] vsel_res_code,
  // soft-start configuration in milliseconds
  input wire logic [ssvs_pkg::MS_CNT_W-1:0] cfg_delay_ms,
  input wire logic [ssvs_pkg::MS_CNT_W-1:0] cfg_ramp_ms,
  // host side
  input wire logic enable,
  input wire logic restore_req,
  input wire logic host_vout_wr,
  input wire logic [ssvs_pkg::MV_W-1:0] host_vout_mv,
  // status
  output logic bus_ready,
  output ssvs_pkg::ssvs_state_t seq_state,
  output logic ramp_active,
  output logic output_on,
  output logic [ssvs_pkg::MV_W-1:0] vout_target_mv,
  output logic [ssvs_pkg::MV_W-1:0] output_voltage_ceiling
);

  localparam int DIV_W = $clog2(MS_DIV + 1);
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(MS_DIV - 1);
  localparam logic [ssvs_pkg::MS_CNT_W-1:0] MEMCHK_LAST =
    ssvs_pkg::MS_CNT_W'(ssvs_pkg::MEMCHK_TIME_MS - 1);
  localparam logic [ssvs_pkg::MS_CNT_W-1:0] PRERAMP_MIN =
    ssvs_pkg::MS_CNT_W'(ssvs_pkg::PRERAMP_MIN_MS);
  localparam logic [ssvs_pkg::MS_CNT_W-1:0] MS_ONE = 8'h01;

  // ==========================================================
  // pin decoding
  ssvs_pin_if vsel ();

  ssvs_pin_decode u_decode (
    .pin_lvl_low(vsel_lvl_low),
    .pin_lvl_high(vsel_lvl_high),
    .pin_res_sense(vsel_res_sense),
    .pin_res_code(vsel_res_code),
    .pin(vsel.dec)
  );

  // ==========================================================
  // sequencer state and millisecond timer
  ssvs_pkg::ssvs_state_t state, next_state;
  logic [DIV_W-1:0] ms_div, next_ms_div;
  logic [ssvs_pkg::MS_CNT_W-1:0] ms_cnt, next_ms_cnt;
  logic [ssvs_pkg::MS_CNT_W-1:0] dly_ms;
  logic supply_ok, ms_tick, ready_zone;

  assign supply_ok = power_stage_supply && bias_supply; // [RQ1]
  assign ms_tick = (ms_div == DIV_LAST);
  // short configured delays are stretched to the internal minimum
  assign dly_ms = (cfg_delay_ms < PRERAMP_MIN) ? PRERAMP_MIN
                                               : cfg_delay_ms; // [RQ10] [RQ11]
  assign ready_zone = (state == ssvs_pkg::ST_READY)
                   || (state == ssvs_pkg::ST_DELAY)
                   || (state == ssvs_pkg::ST_RAMP)
                   || (state == ssvs_pkg::ST_ON);

  always_comb begin
    next_state = state;
    if (!supply_ok) begin
      next_state = ssvs_pkg::ST_OFF;
    end else if (ready_zone && restore_req) begin
      next_state = ssvs_pkg::ST_MEMCHK; // [RQ3]
    end else begin
      case (state)
        ssvs_pkg::ST_OFF: begin
          next_state = ssvs_pkg::ST_MEMCHK; // [RQ1]
        end
        ssvs_pkg::ST_MEMCHK: begin
          // enable is not looked at here, whatever its level
          if (ms_tick && ms_cnt == MEMCHK_LAST) begin // [RQ2] [RQ13]
            next_state = ssvs_pkg::ST_PINLD;
          end
        end
        ssvs_pkg::ST_PINLD: begin
          next_state = ssvs_pkg::ST_READY; // [RQ6]
        end
        ssvs_pkg::ST_READY: begin
          // enable is a level, so one raised early is seen here
          if (enable) begin // [RQ18] [RQ17]
            next_state = ssvs_pkg::ST_DELAY;
          end
        end
        ssvs_pkg::ST_DELAY: begin
          if (!enable) begin
            next_state = ssvs_pkg::ST_READY;
          end else if (ms_tick && ms_cnt == dly_ms - MS_ONE) begin
            next_state = ssvs_pkg::ST_RAMP; // [RQ10] [RQ11]
          end
        end
        ssvs_pkg::ST_RAMP: begin
          if (!enable) begin
            next_state = ssvs_pkg::ST_READY;
          end else if (cfg_ramp_ms == '0
                       || (ms_tick && ms_cnt == cfg_ramp_ms - MS_ONE)) begin
            next_state = ssvs_pkg::ST_ON; // [RQ12]
          end
        end
        ssvs_pkg::ST_ON: begin
          if (!enable) begin
            next_state = ssvs_pkg::ST_READY;
          end
        end
        default: next_state = ssvs_pkg::ST_OFF;
      endcase
    end
    // timer restarts on every state change so each interval is whole
    if (next_state != state) begin
      next_ms_div = '0;
      next_ms_cnt = '0;
    end else if (ms_tick) begin
      next_ms_div = '0;
      next_ms_cnt = (ms_cnt == '1) ? ms_cnt : ms_cnt + MS_ONE;
    end else begin
      next_ms_div = DIV_W'(ms_div + 1'b1);
      next_ms_cnt = ms_cnt;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= ssvs_pkg::ST_OFF;
      ms_div <= '0;
      ms_cnt <= '0;
    end else begin
      state <= next_state;
      ms_div <= next_ms_div;
      ms_cnt <= next_ms_cnt;
    end
  end

  // ==========================================================
  // voltage settings
  logic nvm_hit, next_nvm_hit;
  logic [ssvs_pkg::MV_W-1:0] nvm_mv, next_nvm_mv;
  logic [ssvs_pkg::MV_W-1:0] pin_mv;
  logic [ssvs_pkg::MV_W-1:0] next_target, next_ceiling;
  logic host_ok;

  always_comb begin
    case (vsel.seq.pin_class)
      ssvs_pkg::PIN_LOW: pin_mv = ssvs_pkg::VOUT_STRAP_LOW_MV; // [RQ7]
      ssvs_pkg::PIN_OPEN: pin_mv = ssvs_pkg::VOUT_STRAP_OPEN_MV;
      ssvs_pkg::PIN_HIGH: pin_mv = ssvs_pkg::VOUT_STRAP_HIGH_MV;
      default: pin_mv = ssvs_pkg::ssvs_res_mv(vsel.seq.res_code); // [RQ8]
    endcase
  end

  // writes outside the legal range, or before ready, are dropped
  assign host_ok = bus_ready && host_vout_wr
                && host_vout_mv >= ssvs_pkg::VOUT_MIN_MV
                && host_vout_mv <= ssvs_pkg::OUTPUT_VOLTAGE_CEILING_MV; // [RQ9] [RQ6]

  always_comb begin
    next_nvm_hit = nvm_hit;
    next_nvm_mv = nvm_mv;
    next_target = vout_target_mv;
    next_ceiling = output_voltage_ceiling;
    if (state == ssvs_pkg::ST_MEMCHK) begin
      next_nvm_hit = nvm_valid; // [RQ4]
      next_nvm_mv = nvm_vout_mv;
    end else if (state == ssvs_pkg::ST_PINLD) begin
      // stored user values take precedence over the pin setting
      next_target = nvm_hit ? nvm_mv : pin_mv; // [RQ5] [RQ4]
      next_ceiling = ssvs_pkg::ssvs_ceiling(pin_mv); // [RQ16]
    end else if (host_ok) begin
      next_target = host_vout_mv; // [RQ9]
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      nvm_hit <= 1'b0;
      nvm_mv <= '0;
      vout_target_mv <= '0;
      output_voltage_ceiling <= '0;
    end else begin
      nvm_hit <= next_nvm_hit;
      nvm_mv <= next_nvm_mv;
      vout_target_mv <= next_target;
      output_voltage_ceiling <= next_ceiling;
    end
  end

  // ==========================================================
  // status outputs
  assign bus_ready = ready_zone; // [RQ6]
  assign seq_state = state; // [RQ19]
  assign ramp_active = (state == ssvs_pkg::ST_RAMP); // [RQ12]
  assign output_on = (state == ssvs_pkg::ST_ON);

  // ==========================================================
  // checks
  logic [31:0] dly_cyc;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      dly_cyc <= '0;
    end else if (state != ssvs_pkg::ST_DELAY) begin
      dly_cyc <= '0;
    end else begin
      dly_cyc <= dly_cyc + 32'h0000_0001;
    end
  end

  AST_SUPPLY_START: assert property ( // [RQ1]
    @(posedge sys_clk) disable iff (!rst_n) state == ssvs_pkg::ST_OFF
    && supply_ok |=> state == ssvs_pkg::ST_MEMCHK)
    else $error("supplies present but memory check not started");
  // a write arriving while loading must leave the target untouched
  AST_BUSY_DEAF: assert property ( // [RQ2]
    @(posedge sys_clk) disable iff (!rst_n)
    (state == ssvs_pkg::ST_MEMCHK || state == ssvs_pkg::ST_PINLD)
    |-> !bus_ready && !ramp_active ##1 (vout_target_mv
        == $past(vout_target_mv) || $past(state) == ssvs_pkg::ST_PINLD))
    else $error("bus, ramp or target active while loading");
  AST_RESTORE: assert property ( // [RQ3]
    @(posedge sys_clk) disable iff (!rst_n) bus_ready && restore_req
    && supply_ok |=> state == ssvs_pkg::ST_MEMCHK ##1 !bus_ready)
    else $error("restore did not rerun memory check");
  AST_NVM_LOAD: assert property ( // [RQ4]
    @(posedge sys_clk) disable iff (!rst_n) state == ssvs_pkg::ST_PINLD
    && nvm_hit && supply_ok |=> vout_target_mv == $past(nvm_mv))
    else $error("stored value not loaded");
  AST_STRAP_LOW: assert property ( // [RQ7]
    @(posedge sys_clk) disable iff (!rst_n) state == ssvs_pkg::ST_PINLD
    && !nvm_hit && supply_ok && vsel.pin_class == ssvs_pkg::PIN_LOW
    |=> vout_target_mv == 13'h04B0)
    else $error("low strap did not give 1.2 V");
  AST_RES_TOP: assert property ( // [RQ8]
    @(posedge sys_clk) disable iff (!rst_n) state == ssvs_pkg::ST_PINLD
    && !nvm_hit && supply_ok && vsel.pin_class == ssvs_pkg::PIN_RES
    && vsel.res_code == 5'h1E |=> vout_target_mv == 13'h1388)
    else $error("top resistor code did not give 5.0 V");
  AST_CEIL_HIGH: assert property ( // [RQ16]
    @(posedge sys_clk) disable iff (!rst_n) state == ssvs_pkg::ST_PINLD
    && supply_ok && vsel.pin_class == ssvs_pkg::PIN_HIGH
    |=> output_voltage_ceiling == 13'h0E2E)
    else $error("ceiling not 3.63 V for high strap");
  AST_HOST_WR: assert property ( // [RQ9]
    @(posedge sys_clk) disable iff (!rst_n) host_ok
    && state != ssvs_pkg::ST_PINLD |=> vout_target_mv == $past(host_vout_mv))
    else $error("host target write lost");
  AST_MIN_DELAY: assert property ( // [RQ10]
    @(posedge sys_clk) disable iff (!rst_n) state == ssvs_pkg::ST_DELAY
    && next_state == ssvs_pkg::ST_RAMP
    |-> dly_cyc + 32'h1 >= 32'(ssvs_pkg::PRERAMP_MIN_MS * MS_DIV))
    else $error("ramp began before 2 ms");
  AST_CFG_DELAY: assert property ( // [RQ11]
    @(posedge sys_clk) disable iff (!rst_n) state == ssvs_pkg::ST_DELAY
    && next_state == ssvs_pkg::ST_RAMP
    |-> dly_cyc + 32'h1 >= 32'(cfg_delay_ms) * 32'(MS_DIV))
    else $error("ramp began before configured delay");
  // the ready cycle decides: enable then still high, no restore, supplies up
  AST_EARLY_EN: assert property ( // [RQ18] [RQ17]
    @(posedge sys_clk) disable iff (!rst_n) state == ssvs_pkg::ST_PINLD
    && enable && supply_ok |=> state == ssvs_pkg::ST_READY
    ##1 (state == ssvs_pkg::ST_DELAY || !$past(enable)
         || $past(restore_req) || !$past(supply_ok)))
    else $error("early enable not acted on");
  AST_NO_SKIP: assert property ( // [RQ13]
    @(posedge sys_clk) disable iff (!rst_n) state == ssvs_pkg::ST_MEMCHK
    |=> state inside {ssvs_pkg::ST_MEMCHK, ssvs_pkg::ST_PINLD,
                      ssvs_pkg::ST_OFF})
    else $error("memory check skipped");

endmodule : ssvs_top

//--- tb/ssvs_host_model.sv
// host-side model: drives enable, restore pulses and target writes
// assumes the bench calls its tasks; all changes land on falling edges
`timescale 1ns/1ns
module ssvs_host_model (
  // clock
  input wire logic sys_clk,
  // host requests toward the sequencer
  output logic enable,
  output logic restore_req,
  output logic host_vout_wr,
  output logic [ssvs_pkg::MV_W-1:0] host_vout_mv
);
  // ==========================================================
  // idle levels
  // the sync clock is taken as stable from time zero, so enable may rise
  // at any edge the bench chooses
  initial begin
    enable = 1'b0;
    restore_req = 1'b0;
    host_vout_wr = 1'b0;
    host_vout_mv = 13'h0000;
  end

  // ==========================================================
  // request tasks
  task automatic set_en(input logic v);
    @(negedge sys_clk);
    enable = v;
  endtask : set_en

  // one-cycle pulse; the leading edge wait keeps pulses a cycle apart
  task automatic restore();
    @(negedge sys_clk);
    restore_req = 1'b1;
    @(negedge sys_clk);
    restore_req = 1'b0;
  endtask : restore

  // data is scrambled once the strobe drops so stale values never match
  task automatic write(input logic [ssvs_pkg::MV_W-1:0] mv);
    @(negedge sys_clk);
    host_vout_wr = 1'b1;
    host_vout_mv = mv;
    @(negedge sys_clk);
    host_vout_wr = 1'b0;
    host_vout_mv = ~mv;
  endtask : write
endmodule : ssvs_host_model

//--- tb/ssvs_top_tb.sv
// self-checking bench for the start-up sequencer
// assumes MS_DIV of 10 cycles per millisecond to keep the run short
`timescale 1ns/1ns
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin fails++; \
  $display("unexpected %s expected %0h seen %0h", nm, e, g); end end
module ssvs_top_tb;
  localparam int D = 10;
  logic sys_clk, rst_n, pss, bias, nvm_valid;
  logic [12:0] nvm_mv;
  logic lvl_lo, lvl_hi, res_sense;
  logic [4:0] res_code;
  logic [7:0] dly_ms, ramp_ms;
  logic enable, restore_req, host_wr;
  logic [12:0] host_mv, target, ceil;
  logic bus_ready, ramp_active, output_on;
  ssvs_pkg::ssvs_state_t seq_state;
  int tests_run = 0;
  int fails = 0;
  // the last code lies beyond the table and must clamp to the top entry
  logic [4:0] codes [6] = '{5'h00, 5'h0A, 5'h0B, 5'h1D, 5'h1E, 5'h1F};
  logic [12:0] res_mv [6] = '{13'h0258, 13'h0578, 13'h05DC, 13'h0CE4,
    13'h1388, 13'h1388};
  logic [12:0] res_ceil [6] = '{13'h0294, 13'h0604, 13'h0672, 13'h0E2E,
    13'h157C, 13'h157C};

  ssvs_host_model host (.sys_clk(sys_clk), .enable(enable),
    .restore_req(restore_req), .host_vout_wr(host_wr),
    .host_vout_mv(host_mv));

  ssvs_top #(.MS_DIV(D)) uut (.sys_clk(sys_clk), .rst_n(rst_n),
    .power_stage_supply(pss), .bias_supply(bias), .nvm_valid(nvm_valid),
    .nvm_vout_mv(nvm_mv), .vsel_lvl_low(lvl_lo), .vsel_lvl_high(lvl_hi),
    .vsel_res_sense(res_sense), .vsel_res_code(res_code),
    .cfg_delay_ms(dly_ms), .cfg_ramp_ms(ramp_ms), .enable(enable),
    .restore_req(restore_req), .host_vout_wr(host_wr),
    .host_vout_mv(host_mv), .bus_ready(bus_ready), .seq_state(seq_state),
    .ramp_active(ramp_active), .output_on(output_on),
    .vout_target_mv(target), .output_voltage_ceiling(ceil));

  // ==========================================================
  // clock and closing
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  task automatic results();
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : results

  // about 1000 cycles are needed; a generous margin covers slow paths
  initial begin
    repeat (20000) @(posedge sys_clk);
    fails++;
    $display("unexpected watchdog expected 0 seen 1");
    results();
  end

  // ==========================================================
  // sequencing helpers
  task automatic wait_st(input ssvs_pkg::ssvs_state_t st);
    int n;
    n = 0;
    while (seq_state !== st && n < 2000) begin
      @(negedge sys_clk);
      n++;
    end
    `CHK("state reached", 1, int'(n < 2000))
  endtask : wait_st

  // counts the cycles spent in one state, sampled on falling edges
  task automatic span(input ssvs_pkg::ssvs_state_t st, input int exp);
    int n;
    wait_st(st);
    n = 0;
    while (seq_state === st && n < 2000) begin
      @(negedge sys_clk);
      n++;
    end
    `CHK("state span", exp, n)
  endtask : span

  task automatic reload(input logic [12:0] mv, input logic [12:0] cl);
    host.restore();
    span(ssvs_pkg::ST_MEMCHK, 5 * D);
    span(ssvs_pkg::ST_PINLD, 1);
    `CHK("ready", 1'b1, bus_ready)
    `CHK("target", mv, target)
    `CHK("ceiling", cl, ceil)
  endtask : reload

  // board-side levels; callers change them on falling edges only
  task automatic supplies(input logic p, input logic b);
    pss = p;
    bias = b;
  endtask : supplies

  task automatic strap(input logic lo, input logic hi, input logic rs,
                       input logic [4:0] code);
    lvl_lo = lo;
    lvl_hi = hi;
    res_sense = rs;
    res_code = code;
  endtask : strap

  task automatic board(input logic nv, input logic [12:0] nmv,
                       input logic [7:0] dly, input logic [7:0] ramp);
    nvm_valid = nv;
    nvm_mv = nmv;
    dly_ms = dly;
    ramp_ms = ramp;
  endtask : board

  // ==========================================================
  // main sequence
  initial begin
    rst_n = 1'b0;
    supplies(1'b0, 1'b0);
    strap(1'b0, 1'b0, 1'b0, 5'h00);
    board(1'b0, 13'h09C4, 8'h00, 8'h01);
    repeat (10) @(negedge sys_clk);
    `CHK("reset state", ssvs_pkg::ST_OFF, seq_state)
    `CHK("reset ready", 1'b0, bus_ready)
    rst_n = 1'b1;
    host.set_en(1'b1);
    supplies(1'b1, 1'b0);
    repeat (3) @(negedge sys_clk);
    `CHK("one supply", ssvs_pkg::ST_OFF, seq_state)
    supplies(1'b1, 1'b1);
    wait_st(ssvs_pkg::ST_MEMCHK);
    host.write(13'h0BB8);
    `CHK("early ready", 1'b0, bus_ready)
    `CHK("busy write", 13'h0000, target)
    span(ssvs_pkg::ST_MEMCHK, 5 * D - 2);
    span(ssvs_pkg::ST_PINLD, 1);
    span(ssvs_pkg::ST_READY, 1);
    `CHK("open target", 13'h05DC, target)
    span(ssvs_pkg::ST_DELAY, 2 * D);
    `CHK("ramp flag", 1'b1, ramp_active)
    span(ssvs_pkg::ST_RAMP, D);
    `CHK("on", 1'b1, output_on)
    host.set_en(1'b0);
    @(negedge sys_clk);
    `CHK("disable", ssvs_pkg::ST_READY, seq_state)
    // straps: low, open, high
    strap(1'b1, 1'b0, 1'b0, 5'h00);
    reload(13'h04B0, 13'h0528);
    strap(1'b0, 1'b0, 1'b0, 5'h00);
    reload(13'h05DC, 13'h0672);
    strap(1'b0, 1'b1, 1'b0, 5'h00);
    reload(13'h0CE4, 13'h0E2E);
    // resistor codes win over the high level
    for (int i = 0; i < 6; i++) begin
      strap(1'b0, 1'b1, 1'b1, codes[i]);
      reload(res_mv[i], res_ceil[i]);
    end
    // two stored values in turn, each below the high strap's ceiling
    strap(1'b0, 1'b1, 1'b0, 5'h00);
    board(1'b1, 13'h09C4, 8'h00, 8'h01);
    reload(13'h09C4, 13'h0E2E);
    board(1'b1, 13'h0320, 8'h00, 8'h01);
    reload(13'h0320, 13'h0E2E);
    board(1'b0, 13'h0320, 8'h00, 8'h01);
    // host target writes at and beyond both range ends
    host.write(13'h0258);
    `CHK("wr min", 13'h0258, target)
    host.write(13'h0257);
    `CHK("wr below", 13'h0258, target)
    host.write(13'h1388);
    `CHK("wr max", 13'h1388, target)
    host.write(13'h1389);
    `CHK("wr above", 13'h1388, target)
    `CHK("wr ceiling", 13'h0E2E, ceil)
    // enable dropped mid-delay returns to ready; the next delay is whole
    host.set_en(1'b1);
    wait_st(ssvs_pkg::ST_DELAY);
    host.set_en(1'b0);
    @(negedge sys_clk);
    `CHK("delay abort", ssvs_pkg::ST_READY, seq_state)
    // long configured delay, instant ramp
    board(1'b0, 13'h0320, 8'h03, 8'h00);
    host.set_en(1'b1);
    span(ssvs_pkg::ST_DELAY, 3 * D);
    span(ssvs_pkg::ST_RAMP, 1);
    `CHK("on fast", 1'b1, output_on)
    // restore while on reruns the check, enable stays high
    reload(13'h0CE4, 13'h0E2E);
    span(ssvs_pkg::ST_DELAY, 3 * D);
    // each supply lost in turn drops the sequence
    for (int i = 0; i < 2; i++) begin
      @(negedge sys_clk);
      supplies(i != 0, i == 0);
      @(negedge sys_clk);
      `CHK("supply loss", ssvs_pkg::ST_OFF, seq_state)
      `CHK("loss ready", 1'b0, bus_ready)
      supplies(1'b1, 1'b1);
      span(ssvs_pkg::ST_MEMCHK, 5 * D);
    end
    host.set_en(1'b0);
    results();
  end
endmodule : ssvs_top_tb
